// ==== src/load_shift_register.sv ====
/*
  eight-stage shift register with parallel load; only the last three
  stages are visible. a fill flag tells when the contents are defined.
  assumes: load_select_i, parallel_in_i and serial_in_i are synchronous
  to clk_sys_i, which stands for the shift clock of the part.
*/
`timescale 1ns/1ps
`default_nettype none

module load_shift_register
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control and data in
  input wire logic load_select_i,
  input wire logic [7:0] parallel_in_i,
  input wire logic serial_in_i,
  // data out
  output logic [2:0] tail_stage_out_o,
  output logic contents_valid_o
);

  // ****************************************************************
  // stage chain
  // ****************************************************************
  logic [7:0] stage_q;
  logic [7:0] stage_nxt;

  // load wins over shift; the chain moves toward the last stage
  always_comb
  begin
    if (load_select_i)
    begin
      stage_nxt = parallel_in_i; // [R3]
    end
    else
    begin
      stage_nxt = {stage_q[6:0], serial_in_i}; // [R4] [R5]
    end
  end

  // one cell per stage; no clock enable, every edge updates
  genvar g;
  generate
    for (g = 0; g < shift_pkg::STAGE_COUNT; g++)
    begin : g_stage
      stage_cell u_cell
      (
        .clk_sys_i(clk_sys_i), // [R1] [R2]
        .d_i(stage_nxt[g]),
        .q_o(stage_q[g])
      );
    end
  endgenerate

  // tail outputs are the stage flops themselves, no extra delay
  assign tail_stage_out_o =
    stage_q[shift_pkg::TAIL_LSB +: shift_pkg::TAIL_WIDTH]; // [R6] [R7]

  // ****************************************************************
  // fill tracking
  // ****************************************************************
  // stages have no reset; this counter only reports when all eight
  // hold defined data, so the user need not guess after power-up
  logic [shift_pkg::FILL_WIDTH-1:0] fill_r;
  logic [shift_pkg::FILL_WIDTH-1:0] fill_nxt;
  logic valid_r;
  logic valid_nxt;

  always_comb
  begin
    fill_nxt = fill_r;
    if (rst_i)
    begin
      fill_nxt = shift_pkg::FILL_RESET;
    end
    else if (load_select_i)
    begin
      fill_nxt = shift_pkg::FILL_FULL; // [R9]
    end
    else if (fill_r != shift_pkg::FILL_FULL)
    begin
      fill_nxt = fill_r + shift_pkg::FILL_STEP; // [R9]
    end
    valid_nxt = (fill_nxt == shift_pkg::FILL_FULL);
  end

  always_ff @(posedge clk_sys_i)
  begin
    fill_r <= fill_nxt;
    valid_r <= valid_nxt;
  end

  assign contents_valid_o = valid_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_shift6;
    (!load_select_i) [*6];
  endsequence

  sequence s_shift7;
    (!load_select_i) [*7];
  endsequence

  sequence s_shift8;
    (!load_select_i) [*8];
  endsequence

  // a load followed at once by a shift
  sequence s_load_shift;
    load_select_i ##1 !load_select_i;
  endsequence

  property p_load_all;
    @(posedge clk_sys_i) disable iff (rst_i)
    load_select_i |=> stage_q == $past(parallel_in_i);
  endproperty
  a_load_all: assert property (p_load_all) // [R3]
    else $error("parallel load did not fill all stages");

  property p_load_tail;
    @(posedge clk_sys_i) disable iff (rst_i)
    load_select_i |=> tail_stage_out_o == $past(parallel_in_i[7:5]);
  endproperty
  a_load_tail: assert property (p_load_tail) // [R7]
    else $error("top parallel bits not on tail after load");

  property p_serial_first;
    @(posedge clk_sys_i) disable iff (rst_i)
    !load_select_i |=> stage_q[0] == $past(serial_in_i);
  endproperty
  a_serial_first: assert property (p_serial_first) // [R4]
    else $error("serial input not captured in first stage");

  property p_shift_move;
    @(posedge clk_sys_i) disable iff (rst_i)
    !load_select_i |=> stage_q[7:1] == $past(stage_q[6:0]);
  endproperty
  a_shift_move: assert property (p_shift_move) // [R5]
    else $error("chain did not move one place");

  // loaded bits must move on, not be reloaded, at the next shift
  property p_load_then_shift;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_load_shift |=> tail_stage_out_o == $past(parallel_in_i[6:4], 2);
  endproperty
  a_load_then_shift: assert property (p_load_then_shift) // [R5]
    else $error("loaded bits did not shift one place");

  property p_tail_from_hidden;
    @(posedge clk_sys_i) disable iff (rst_i)
    !load_select_i |=> tail_stage_out_o[0] == $past(stage_q[4]);
  endproperty
  a_tail_from_hidden: assert property (p_tail_from_hidden) // [R6]
    else $error("sixth stage not fed from fifth");

  property p_sixth_edge;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_shift6 |=> tail_stage_out_o[0] == $past(serial_in_i, 6);
  endproperty
  a_sixth_edge: assert property (p_sixth_edge) // [R7]
    else $error("serial bit not on sixth stage after six edges");

  property p_seventh_edge;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_shift7 |=> tail_stage_out_o[1] == $past(serial_in_i, 7);
  endproperty
  a_seventh_edge: assert property (p_seventh_edge) // [R7]
    else $error("serial bit not on seventh stage after seven edges");

  property p_eighth_edge;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_shift8 |=> tail_stage_out_o[2] == $past(serial_in_i, 8);
  endproperty
  a_eighth_edge: assert property (p_eighth_edge) // [R7]
    else $error("serial bit not on eighth stage after eight edges");

  // every one of the eight stages holds one of the last eight bits
  property p_chain_length;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_shift8 |=> stage_q == {$past(serial_in_i, 8),
      $past(serial_in_i, 7), $past(serial_in_i, 6),
      $past(serial_in_i, 5), $past(serial_in_i, 4),
      $past(serial_in_i, 3), $past(serial_in_i, 2),
      $past(serial_in_i)};
  endproperty
  a_chain_length: assert property (p_chain_length) // [R1]
    else $error("chain is not eight stages long");

  property p_fill_after_reset;
    @(posedge clk_sys_i)
    rst_i ##1 (!rst_i && !load_select_i) [*7] |=> !contents_valid_o;
  endproperty
  a_fill_after_reset: assert property (p_fill_after_reset) // [R9]
    else $error("contents flagged valid before eight shifts");

  property p_fill_on_load;
    @(posedge clk_sys_i) disable iff (rst_i)
    load_select_i |=> contents_valid_o;
  endproperty
  a_fill_on_load: assert property (p_fill_on_load) // [R9]
    else $error("contents not flagged valid after load");

  property p_fill_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    contents_valid_o && !load_select_i |=> contents_valid_o;
  endproperty
  a_fill_hold: assert property (p_fill_hold) // [R9]
    else $error("valid flag dropped while shifting");

  // counter saturates; a wrap would drop the valid flag while all stages still hold defined data
  property p_fill_bound;
    @(posedge clk_sys_i) disable iff (rst_i)
    fill_r <= shift_pkg::FILL_FULL;
  endproperty
  a_fill_bound: assert property (p_fill_bound) // [R9]
    else $error("fill counter ran past full");

  property p_edge_only;
    @(posedge clk_sys_i) disable iff (rst_i)
    1'b1 |=> stage_q == $past(stage_nxt);
  endproperty
  a_edge_only: assert property (p_edge_only) // [R2]
    else $error("stages did not take their next value at the edge");

endmodule

`default_nettype wire

// ==== shared/shift_pkg.sv ====
/*
  constants for the eight-stage load/shift register: chain length,
  the tail window that is brought out, and fill-tracking counts.
  assumes: a single clock drives every stage; nothing else shares it.

  // Overview of operation
  // [R1] eight storage stages form one fully synchronous shift register
  // [R2] stages change only on a rising clock edge, never otherwise
  // [R3] load_select high at an edge loads all eight stages in parallel
  // [R4] load_select low at an edge captures serial_in into stage one
  // [R5] on a shift every stage takes its lower neighbour's old value
  // [R6] only stages six, seven and eight drive the tail outputs
  // [R7] serial bit reaches stage six after six edges, eight after eight
  // [R8] each stage is an edge-triggered d element holding its value
  // [R9] no reset on stages; contents unknown until filled or loaded
*/
`default_nettype none

package shift_pkg;

  // ****************************************************************
  // chain geometry
  // ****************************************************************
  localparam int STAGE_COUNT = 8;
  localparam int TAIL_LSB = 5;
  localparam int TAIL_WIDTH = 3;

  // ****************************************************************
  // fill tracking
  // ****************************************************************
  localparam int FILL_WIDTH = 4;
  localparam logic [3:0] FILL_RESET = 4'h0;
  localparam logic [3:0] FILL_FULL = 4'h8;
  localparam logic [3:0] FILL_STEP = 4'h1;

endpackage

`default_nettype wire

// ==== src/stage_cell.sv ====
/*
  one storage stage of the chain: a plain d element with no reset.
  assumes: the parent computes the next value every cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module stage_cell
(
  // clock
  input wire logic clk_sys_i,
  // data
  input wire logic d_i,
  output logic q_o
);

  logic q_r;
  logic q_nxt;

  always_comb
  begin
    q_nxt = d_i;
  end

  // no reset: holds indefinitely between edges, no minimum rate
  always_ff @(posedge clk_sys_i)
  begin
    q_r <= q_nxt; // [R8]
  end

  assign q_o = q_r;

endmodule

`default_nettype wire

// ==== sim/stim_source.sv ====
/*
  far-side driver: load_select, parallel and serial data from xorshift.
  assumes: bench clock; mode 0 random, 1 shift only, 2 load only.
*/
`timescale 1ns/1ps
`default_nettype none

module stim_source
(
  // clock and mode
  input wire logic clk_sys_i,
  input wire logic [1:0] mode_i,
  // toward the block
  output logic load_select_o,
  output logic [7:0] parallel_in_o,
  output logic serial_in_o
);
  logic [31:0] rng = 32'h8e6e;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // one process owns the outputs; enable held as a level for the edge
  initial
  begin
    load_select_o = 1'b0;
    parallel_in_o = 8'h00;
    serial_in_o = 1'b0;
    forever
    begin
      @(posedge clk_sys_i);
      rng <= xs(rng);
      load_select_o <= (mode_i == 2'h0) ? rng[9] : mode_i[1];
      parallel_in_o <= rng[23:16];
      serial_in_o <= rng[3];
    end
  end
endmodule

`default_nettype wire

// ==== sim/tb_load_shift_register.sv ====
/*
  self-checking bench: shadow chain plus known-bit mask, random traffic.
  assumes: stim_source drives the block; one clock at 10 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_load_shift_register;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] mode = 2'h1;
  logic ld, sin, vld;
  logic [7:0] pin, exp_r;
  // stages start unknown, so only bits known to the model are compared
  logic [7:0] kn_r = 8'h00;
  logic [2:0] tail;
  logic [3:0] fill_r = 4'h0;
  int n_mismatch = 0;
  int checks_done = 0;

  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  stim_source src_u (.clk_sys_i(clk_sys_i), .mode_i(mode),
    .load_select_o(ld), .parallel_in_o(pin), .serial_in_o(sin));

  load_shift_register dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .load_select_i(ld), .parallel_in_i(pin), .serial_in_i(sin),
    .tail_stage_out_o(tail), .contents_valid_o(vld));

  // ******************************************************
  // expectation
  // ******************************************************
  function automatic logic [7:0] stage_next(logic [7:0] s, logic l,
    logic [7:0] p, logic d);
    return l ? p : {s[6:0], d};
  endfunction

  function automatic logic [3:0] fill_next(logic [3:0] f, logic r,
    logic l);
    return r ? 4'h0 : (l || f == 4'h8) ? 4'h8 : f + 4'h1;
  endfunction

  always @(posedge clk_sys_i)
  begin
    exp_r <= stage_next(exp_r, ld, pin, sin);
    kn_r <= ld ? 8'hff : {kn_r[6:0], 1'b1};
    fill_r <= fill_next(fill_r, rst_i, ld);
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic cmp_all;
    logic [2:0] seen_t;
    logic [2:0] want_t;
    seen_t = tail & kn_r[7:5];
    want_t = exp_r[7:5] & kn_r[7:5];
    check({5'h00, seen_t}, {5'h00, want_t});
    check({7'h00, vld}, {7'h00, fill_r == 4'h8});
  endtask

  // second look just before the edge: nothing moves on the falling edge
  always @(negedge clk_sys_i)
  begin
    cmp_all;
    #40 cmp_all;
  end

  // ******************************************************
  // sequence
  // ******************************************************
  task automatic run(input logic [1:0] m, input int n, input string nm);
    mode <= m;
    repeat (n) @(posedge clk_sys_i);
    $display("test %s done", nm);
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    run(2'h1, 12, "serial_fill");
    run(2'h2, 4, "load_back_to_back");
    run(2'h0, 300, "random_mix");
    rst_i <= 1'b1;
    run(2'h1, 3, "reset_midrun");
    rst_i <= 1'b0;
    run(2'h1, 10, "refill_count");
    wrap_up;
  end

  // run needs about 340 cycles
  initial
  begin
    #60000;
    n_mismatch++;
    wrap_up;
  end
endmodule

`default_nettype wire
